/* File: core/pawb_bridge.sv */
// Processor to peripheral bus bridge with access wait control
//
// Summary of operation
// [RQ1] Watchdog runs after reset before mode write
// [RQ2] Peripheral clock treated asynchronous, synchronized here
// [RQ3] Processor held waiting until access completes
// [RQ4] Listed registers get extra waits
// [RQ5] Clocks equal 3+i+j+(2+j)*k
// [RQ6] i upper nibble, j lower nibble
// [RQ7] Timer count and compare reads k 1/2
// [RQ8] First compare write plain, continuous k 3/4
// [RQ9] Watchdog mode write while running k 3
// [RQ10] Buffer write with output disabled k 1
// [RQ11] Processor avoids listed registers on slow clocks
// [RQ12] Prohibited listed access stalls until reset
// [RQ13] Unwaited access takes three clocks
// [RQ14] Wait config resets to 77H
// [RQ15] Other registers use base plus config waits
module pawb_bridge (
   input  wire logic              mclk,
   input  wire logic              rst,
   input  wire logic              cpu_req,
   input  wire logic              cpu_we,
   input  wire pawb_pkg::pawb_class_e cpu_class,
   input  wire logic [7:0]        cpu_wdata,
   output logic                   cpu_wait,
   output logic                   cpu_ack,
   output logic [7:0]             cpu_rdata,
   input  wire logic              pclk_in,
   input  wire logic [7:0]        per_rdata,
   output logic                   per_strobe,
   output logic                   per_we,
   output pawb_pkg::pawb_class_e  per_class,
   output logic [7:0]             per_wdata,
   input  wire logic              clk_sub_only,
   input  wire logic              clk_int_osc,
   input  wire logic              realtime_output_enable,
   output logic [7:0]             peripheral_wait_config,
   output logic                   watchdog_running,
   output logic                   stalled_forever
);
   import pawb_pkg::*;
   `include "pawb_defs.svh"

   typedef enum logic [1:0] {PAWB_IDLE, PAWB_BUSY, PAWB_STUCK} pawb_state_e;

   pawb_wait_if wif ();                // Counter link
   pawb_state_e state_r;               // Bridge state
   pawb_class_e class_r;               // Class of access in flight
   logic        we_r;                  // Direction of access in flight
   logic [7:0]  wdata_r;               // Write data in flight
   logic [7:0]  wcfg_r;                // Wait configuration
   logic        wdt_run_r;             // Watchdog running
   logic        last_cmp_wr_r;         // Previous access was a compare write
   logic [2:0]  psync_r;               // Peripheral clock synchronizer
   logic        phase_r;               // Settled peripheral clock level
   logic [7:0]  rdata_r;               // Read data
   logic        strobe_r;              // Peripheral strobe
   logic [3:0]  wait_i;                // Upper nibble term
   logic [3:0]  wait_j;                // Lower nibble term
   pawb_cnt_t   k_val;                 // Register factor
   pawb_cnt_t   total;                 // Total clocks of the access
   logic        listed;                // Access is to a listed register (extra waits unless first compare write, stalls on slow clocks)
   logic        take;                  // Request accepted this cycle

   // Three stage sampling of the peripheral clock
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         psync_r <= `PAWB_SYNC_ZERO;
      end else begin
         psync_r <= {psync_r[1:0], pclk_in}; // RQ2
      end
   end

   // Level counts once stages two and three agree
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         phase_r <= 1'b0;
      end else if (psync_r[1] == psync_r[2]) begin
         phase_r <= psync_r[2]; // RQ2
      end
   end

   // Nibbles of the wait configuration
   assign wait_i = wcfg_r[`PAWB_I_HI:`PAWB_I_LO]; // RQ6
   assign wait_j = wcfg_r[`PAWB_J_HI:`PAWB_J_LO]; // RQ6

   // Factor k by register class and direction
   always_comb begin
      k_val  = `PAWB_K_NONE;
      listed = 1'b0;
      case (cpu_class)
         PAWB_TP_CNT, PAWB_TQ_CNT: begin
            // Count value reads, phase picks 1 or 2
            if (!cpu_we) begin
               listed = 1'b1;
               k_val  = `PAWB_K_READ + {7'h00, phase_r}; // RQ7
            end
         end
         PAWB_TP_CMP, PAWB_TQ_CMP: begin
            listed = 1'b1;
            if (!cpu_we) begin
               k_val = `PAWB_K_READ + {7'h00, phase_r}; // RQ7
            end else if (last_cmp_wr_r) begin
               k_val = `PAWB_K_CONT + {7'h00, phase_r}; // RQ8
            end else begin
               k_val = `PAWB_K_NONE; // RQ8
            end
         end
         PAWB_WDT_MODE: begin
            // Only while the watchdog runs
            if (cpu_we && wdt_run_r) begin
               listed = 1'b1;
               k_val  = `PAWB_K_WDT; // RQ9
            end
         end
         PAWB_RT_BUF: begin
            // Only while real time output is disabled
            if (cpu_we && !realtime_output_enable) begin
               listed = 1'b1;
               k_val  = `PAWB_K_RTB; // RQ10
            end
         end
         default: begin
            k_val  = `PAWB_K_NONE; // RQ15
            listed = 1'b0;
         end
      endcase
   end

   // Total access clocks from the formula
   assign total = `PAWB_BASE_CLKS + {4'h0, wait_i} + {4'h0, wait_j}
                + 8'((`PAWB_J_ADD + {4'h0, wait_j}) * k_val); // RQ5 RQ4 RQ13

   assign take = (state_r == PAWB_IDLE) && cpu_req;

   // Counter runs for all clocks but request and ack cycles
   assign wif.load  = take && !(listed && (clk_sub_only || clk_int_osc));
   assign wif.count = total - `PAWB_CNT_TWO;

   pawb_wait_timer u_timer (
      .mclk (mclk),
      .rst  (rst),
      .wif  (wif)
   );

   // Bridge state machine
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_r <= PAWB_IDLE;
      end else begin
         case (state_r)
            PAWB_IDLE: begin
               if (take && listed && (clk_sub_only || clk_int_osc)) begin
                  state_r <= PAWB_STUCK; // RQ12
               end else if (take) begin
                  state_r <= PAWB_BUSY;
               end
            end
            PAWB_BUSY: begin
               if (wif.done) begin
                  state_r <= PAWB_IDLE;
               end
            end
            PAWB_STUCK: begin
               state_r <= PAWB_STUCK; // RQ12
            end
            default: begin
               state_r <= PAWB_IDLE;
            end
         endcase
      end
   end

   // Capture the access in flight
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         class_r <= PAWB_OTHER;
         we_r    <= 1'b0;
         wdata_r <= `PAWB_BYTE_ZERO;
      end else if (take) begin
         class_r <= cpu_class;
         we_r    <= cpu_we;
         wdata_r <= cpu_wdata;
      end
   end

   // Continuous compare write tracking
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         last_cmp_wr_r <= 1'b0;
      end else if (take) begin
         last_cmp_wr_r <= cpu_we && (cpu_class == PAWB_TP_CMP || cpu_class == PAWB_TQ_CMP); // RQ8
      end
   end

   // Wait configuration register
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wcfg_r <= `PAWB_WCFG_RST; // RQ14
      end else if (cpu_ack && we_r && class_r == PAWB_WAIT_CFG) begin
         wcfg_r <= wdata_r;
      end
   end

   // Watchdog runs from reset until a stop write
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wdt_run_r <= 1'b1; // RQ1
      end else if (cpu_ack && we_r && class_r == PAWB_WDT_MODE) begin
         wdt_run_r <= !wdata_r[`PAWB_WDT_STOP_BIT];
      end
   end

   // Peripheral side strobe one cycle after completion, read data at completion
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         strobe_r <= 1'b0;
         rdata_r  <= `PAWB_BYTE_ZERO;
      end else begin
         strobe_r <= cpu_ack;
         if (cpu_ack && !we_r) begin
            rdata_r <= per_rdata;
         end
      end
   end

   // Processor handshake
   assign cpu_ack  = (state_r == PAWB_BUSY) && wif.done;
   assign cpu_wait = take || (state_r == PAWB_STUCK) || ((state_r == PAWB_BUSY) && !wif.done); // RQ3

   assign cpu_rdata              = rdata_r;
   assign per_strobe             = strobe_r;
   assign per_we                 = we_r;
   assign per_class              = class_r;
   assign per_wdata              = wdata_r;
   assign peripheral_wait_config = wcfg_r;
   assign watchdog_running       = wdt_run_r;
   assign stalled_forever        = (state_r == PAWB_STUCK);
endmodule

/* File: include/pawb_defs.svh */
// Constants for the peripheral access wait bridge
`ifndef PAWB_DEFS_SVH
`define PAWB_DEFS_SVH
`define PAWB_WCFG_RST     8'h77
`define PAWB_BASE_CLKS    8'h03
`define PAWB_J_ADD        8'h02
`define PAWB_K_NONE       8'h00
`define PAWB_K_READ       8'h01
`define PAWB_K_CONT       8'h03
`define PAWB_K_WDT        8'h03
`define PAWB_K_RTB        8'h01
`define PAWB_I_HI         7
`define PAWB_I_LO         4
`define PAWB_J_HI         3
`define PAWB_J_LO         0
`define PAWB_WDT_STOP_BIT 7
`define PAWB_CNT_ONE      8'h01
`define PAWB_CNT_TWO      8'h02
`define PAWB_CNT_ZERO     8'h00
`define PAWB_BYTE_ZERO    8'h00
`define PAWB_SYNC_ZERO    3'h0
`endif

/* File: include/pawb_pkg.sv */
// Types for the peripheral access wait bridge
package pawb_pkg;
   // Class of the peripheral register addressed
   typedef enum logic [2:0] {
      PAWB_OTHER,
      PAWB_TP_CNT,
      PAWB_TP_CMP,
      PAWB_TQ_CNT,
      PAWB_TQ_CMP,
      PAWB_WDT_MODE,
      PAWB_RT_BUF,
      PAWB_WAIT_CFG
   } pawb_class_e;
   typedef logic [7:0] pawb_cnt_t;
endpackage

/* File: include/pawb_wait_if.sv */
// Link between the bridge control and its wait counter
interface pawb_wait_if;
   logic             load;   // Start a new count
   logic [7:0]       count;  // Cycles to wait after the load edge
   logic             done;   // Count reached zero
   logic             busy;   // Count in progress
   modport ctrl (output load, output count, input done, input busy);
   modport cnt  (input load, input count, output done, output busy);
endinterface

/* File: core/pawb_wait_timer.sv */
// Down counter that times one stalled access
module pawb_wait_timer (
   input  wire logic mclk,
   input  wire logic rst,
   pawb_wait_if.cnt  wif
);
   import pawb_pkg::*;
   `include "pawb_defs.svh"

   pawb_cnt_t cnt_r;   // Remaining cycles
   logic      busy_r;  // Counting

   // Load on request, count down, stop at zero
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt_r  <= `PAWB_CNT_ZERO;
         busy_r <= 1'b0;
      end else if (wif.load) begin
         cnt_r  <= wif.count;
         busy_r <= 1'b1;
      end else if (busy_r && cnt_r != `PAWB_CNT_ZERO) begin
         cnt_r  <= cnt_r - `PAWB_CNT_ONE;
      end else begin
         busy_r <= 1'b0;
      end
   end

   // Done in the last counted cycle
   assign wif.done = busy_r && (cnt_r == `PAWB_CNT_ZERO);
   assign wif.busy = busy_r;
endmodule

/* File: bench/pawb_monitor.sv */
// Port checker for the peripheral access wait bridge
module pawb_monitor (
   input wire logic       mclk,
   input wire logic       rst,
   input wire logic       cpu_wait,
   input wire logic       cpu_ack,
   input wire logic [7:0] cpu_rdata,
   input wire logic       per_strobe,
   input wire logic       per_we,
   input wire logic [7:0] peripheral_wait_config,
   input wire logic       watchdog_running,
   input wire logic       stalled_forever
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // Two quiet cycles after an ack
   sequence ack_gap_s;
      !cpu_ack [*2];
   endsequence
   a_reset_cfg_value: assert property ($fell(rst) |-> peripheral_wait_config == 8'h77 && watchdog_running)
      else $error("reset values wrong");
   a_ack_spacing: assert property (cpu_ack |=> ack_gap_s)
      else $error("access shorter than three clocks");
   a_ack_ends_wait: assert property (cpu_ack |-> !cpu_wait)
      else $error("wait high with ack");
   a_wait_bounded: assert property (cpu_wait |-> ##[0:117] (cpu_ack || stalled_forever))
      else $error("wait too long");
   a_strobe_follows: assert property (per_strobe == $past(cpu_ack))
      else $error("strobe not after ack");
   a_stall_sticks: assert property (stalled_forever |=> stalled_forever && cpu_wait && !cpu_ack)
      else $error("stall released");
   a_cfg_at_ack: assert property ($changed(peripheral_wait_config) |-> $past(cpu_ack))
      else $error("config changed off ack");
   a_rdata_at_read: assert property ($changed(cpu_rdata) |-> $past(cpu_ack && !per_we))
      else $error("read data changed off read");
   a_wdt_stop_write: assert property ($fell(watchdog_running) |-> $past(cpu_ack && per_we))
      else $error("watchdog stopped without write");
endmodule
bind pawb_bridge pawb_monitor u_pawb_monitor (.mclk, .rst, .cpu_wait, .cpu_ack, .cpu_rdata, .per_strobe,
   .per_we, .peripheral_wait_config, .watchdog_running, .stalled_forever);

/* File: bench/pawb_periph.sv */
// Peripheral side model: bus clock level and register store
module pawb_periph (
   input  wire logic                  mclk,
   input  wire logic                  rst,
   input  wire logic                  pclk_lvl,
   output logic                       pclk_in,
   input  wire logic                  per_strobe,
   input  wire logic                  per_we,
   input  wire pawb_pkg::pawb_class_e per_class,
   input  wire logic [7:0]            per_wdata,
   output logic [7:0]                 per_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   import pawb_pkg::*;
   logic [7:0] store_r [8];  // One byte per register class
   // Clock held at a set level so the bench knows the phase
   assign pclk_in = pclk_lvl;
   assign per_rdata = store_r[per_class];
   // Store written bytes on the strobe
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int c = 0; c < 8; c++) store_r[c] <= 8'hA5 ^ 8'(c);
      end else if (per_strobe && per_we) begin
         store_r[per_class] <= per_wdata;
      end
   end
endmodule

/* File: bench/tb_pawb_bridge.sv */
// Self-checking bench for the peripheral access wait bridge
module tb_pawb_bridge;
   timeunit 1ns;
   timeprecision 1ns;
   import pawb_pkg::*;
   `define CHK(nm, e, a) begin checks_done++; if ((e) !== (a)) begin err_total++; \
      $display("[FAIL] %s exp %h got %h", nm, e, a); end end
   typedef struct {pawb_cnt_t n; logic rd; logic [7:0] d;} pawb_exp_s;
   logic mclk, rst, cpu_req, cpu_we, cpu_wait, cpu_ack, pclk_in, pclk_lvl, per_strobe, per_we;
   logic clk_sub_only, clk_int_osc, realtime_output_enable, watchdog_running, stalled_forever;
   logic [7:0] cpu_wdata, cpu_rdata, per_rdata, per_wdata, peripheral_wait_config;
   pawb_class_e cpu_class, per_class;
   logic        rchk = 1'b0;    // Read data due this edge
   logic [15:0] lfsr = 16'hC89B; // Seed
   logic [7:0]  mirror [8];     // Expected peripheral store
   int          err_total, checks_done, cyc, nwait;
   pawb_exp_s   q[$];
   pawb_exp_s   cur;
   pawb_bridge u_pawb_bridge (.mclk, .rst, .cpu_req, .cpu_we, .cpu_class, .cpu_wdata, .cpu_wait, .cpu_ack,
      .cpu_rdata, .pclk_in, .per_rdata, .per_strobe, .per_we, .per_class, .per_wdata, .clk_sub_only,
      .clk_int_osc, .realtime_output_enable, .peripheral_wait_config, .watchdog_running, .stalled_forever);
   pawb_periph u_pawb_periph (.mclk, .rst, .pclk_lvl, .pclk_in, .per_strobe, .per_we, .per_class,
      .per_wdata, .per_rdata);
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   function automatic logic [7:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr[7:0];
   endfunction
   task automatic end_sim();
      if (err_total == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // One access: set phase, request, hold until ack
   task automatic acc(logic we, pawb_class_e cl, logic [7:0] d, logic ph, logic rte, pawb_cnt_t n);
      pawb_exp_s e;
      int        w;
      @(negedge mclk);
      pclk_lvl = ph;
      realtime_output_enable = rte;
      repeat (4) @(negedge mclk);
      e.n = n;
      e.rd = !we;
      e.d = mirror[cl];
      if (we) mirror[cl] = d;
      q.push_back(e);
      cpu_req = 1'b1;
      cpu_we = we;
      cpu_class = cl;
      cpu_wdata = d;
      w = 0;
      do begin
         @(posedge mclk);
         w++;
      end while (!cpu_ack && w < 200);
      `CHK("ack_seen", 1'b1, cpu_ack)
      @(negedge mclk);
      cpu_req = 1'b0;
   endtask
   // Timeout and result watcher
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         end_sim();
      end
      if (rchk) `CHK("cpu_rdata", cur.d, cpu_rdata)
      rchk = 1'b0;
      if (rst) nwait = 0;
      else if (cpu_ack) begin
         cur = q.pop_front();
         `CHK("access_clocks", cur.n, pawb_cnt_t'(nwait + 1))
         rchk = cur.rd;
         nwait = 0;
      end else if (cpu_wait) nwait++;
   end
   initial begin
      {rst, pclk_lvl} = 2'b10;
      {cpu_req, cpu_we, clk_sub_only, clk_int_osc, realtime_output_enable} = 5'h00;
      cpu_class = PAWB_OTHER;
      cpu_wdata = 8'h00;
      for (int c = 0; c < 8; c++) mirror[c] = 8'hA5 ^ 8'(c);
      repeat (16) @(negedge mclk);
      rst = 1'b0;
      `CHK("wait_config", 8'h77, peripheral_wait_config)
      `CHK("watchdog_running", 1'b1, watchdog_running)
      acc(0, PAWB_OTHER, 8'h00, 0, 0, 17);
      acc(1, PAWB_WAIT_CFG, 8'h00, 0, 0, 17);
      acc(0, PAWB_OTHER, 8'h00, 1, 0, 3);
      acc(0, PAWB_TP_CNT, 8'h00, 0, 0, 5);
      acc(0, PAWB_TQ_CNT, 8'h00, 1, 0, 7);
      acc(1, PAWB_TP_CMP, rnd(), 1, 0, 3);
      acc(1, PAWB_TQ_CMP, rnd(), 0, 0, 9);
      acc(1, PAWB_TP_CMP, rnd(), 1, 0, 11);
      acc(0, PAWB_TQ_CMP, 8'h00, 1, 0, 7);
      acc(1, PAWB_RT_BUF, rnd(), 0, 0, 5);
      acc(1, PAWB_RT_BUF, rnd(), 0, 1, 3);
      acc(1, PAWB_WDT_MODE, 8'h01, 0, 0, 9);
      acc(1, PAWB_WDT_MODE, 8'h80, 0, 0, 9);
      `CHK("watchdog_running", 1'b0, watchdog_running)
      acc(1, PAWB_WDT_MODE, 8'h01, 0, 0, 3);
      acc(1, PAWB_WAIT_CFG, 8'h01, 0, 0, 3);
      `CHK("wait_config", 8'h01, peripheral_wait_config)
      acc(0, PAWB_TP_CNT, 8'h00, 0, 0, 7);
      acc(0, PAWB_TP_CMP, 8'h00, 1, 0, 10);
      // Listed access on a slow clock, then recovery by reset
      for (int p = 0; p < 2; p++) begin
         @(negedge mclk);
         clk_sub_only = (p == 0);
         clk_int_osc = (p == 1);
         {cpu_req, cpu_we} = 2'b10;
         cpu_class = PAWB_TP_CNT;
         repeat (150) @(negedge mclk);
         `CHK("stalled_forever", 1'b1, stalled_forever)
         `CHK("cpu_wait", 1'b1, cpu_wait)
         {rst, cpu_req, clk_sub_only, clk_int_osc} = 4'h8;
         repeat (16) @(negedge mclk);
         rst = 1'b0;
         `CHK("stalled_forever", 1'b0, stalled_forever)
      end
      acc(0, PAWB_OTHER, 8'h00, 0, 0, 17);
      @(negedge mclk);
      `CHK("pending_results", 0, q.size())
      end_sim();
   end
endmodule
